//--- dv/button_tuning_props.sv
`timescale 1ns/100ps
`default_nettype none
module button_tuning_props
	import button_tuning_pkg::*;
(
	// Watched ports of the register block
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic REG_WR_EN,
	input wire logic REG_RD_EN,
	input wire logic [7:0] REG_ADDR,
	input wire cfg_byte_t REG_WDATA,
	input wire cfg_byte_t REG_RDATA,
	input wire logic REG_RD_VALID,
	input wire logic REG_HIT,
	input wire logic BUTTON_A,
	input wire step_t NORMAL_TRACK_STEP,
	input wire chan_mask_t TRACK_ENABLE,
	input wire chan_mask_t STRONGEST_WINS,
	input wire divider_t OSC_DIVIDER,
	input wire margin_t THRESHOLD_MARGIN,
	input wire guard_thr_t GUARD_THRESHOLD
);
	// --------------------
	// Checks
	// --------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	logic mapped;
	assign mapped = REG_ADDR >= 8'h15 && REG_ADDR <= 8'h19;
	property p_step;
		REG_WR_EN && REG_ADDR == 8'h15 |=>
			NORMAL_TRACK_STEP == $past(REG_WDATA[2:0]);
	endproperty
	a_step: assert property (p_step) else $error("step not stored");
	property p_hold;
		!TRACK_ENABLE[0] |-> $past(BUTTON_A);
	endproperty
	a_hold: assert property (p_hold) else $error("hold without press");
	property p_wins;
		REG_WR_EN && REG_ADDR == 8'h16 |=>
			STRONGEST_WINS == $past(REG_WDATA[3:0]);
	endproperty
	a_wins: assert property (p_wins) else $error("group not stored");
	property p_div;
		REG_WR_EN && REG_ADDR == 8'h17 |=>
			OSC_DIVIDER == $past(REG_WDATA[2:0]);
	endproperty
	a_div: assert property (p_div) else $error("divider not stored");
	property p_margin;
		REG_WR_EN && REG_ADDR == 8'h18 |=> ##1
			THRESHOLD_MARGIN == {$past(REG_WDATA[3:0], 2), 2'b00};
	endproperty
	a_margin: assert property (p_margin) else $error("margin wrong");
	property p_guard;
		REG_WR_EN && REG_ADDR == 8'h19 |=> ##1
			GUARD_THRESHOLD == {$past(REG_WDATA[2:0], 2), 2'b00};
	endproperty
	a_guard: assert property (p_guard) else $error("guard wrong");
	property p_hit;
		REG_RD_EN && mapped |=> REG_RD_VALID && REG_HIT;
	endproperty
	a_hit: assert property (p_hit) else $error("mapped read missed");
	property p_unmapped;
		REG_RD_EN && !mapped |=>
			REG_RD_VALID && !REG_HIT && REG_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("stray hit");
	property p_wr_hit;
		REG_WR_EN && mapped |=> REG_HIT;
	endproperty
	a_wr_hit: assert property (p_wr_hit) else $error("write missed");
endmodule : button_tuning_props
bind button_algo_tuning_regs button_tuning_props i_button_tuning_props (
	.CLK, .RST_B, .REG_WR_EN, .REG_RD_EN, .REG_ADDR, .REG_WDATA,
	.REG_RDATA, .REG_RD_VALID, .REG_HIT, .BUTTON_A, .NORMAL_TRACK_STEP,
	.TRACK_ENABLE, .STRONGEST_WINS, .OSC_DIVIDER, .THRESHOLD_MARGIN,
	.GUARD_THRESHOLD
);
`default_nettype wire

//--- dv/test_button_algo_tuning_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_button_algo_tuning_regs;
	import button_tuning_pkg::*;
	// --------------------
	// Stimulus and checking
	// --------------------
	logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic rd_valid, hit, void_all;
	logic [7:0] addr = 8'h00;
	cfg_byte_t wdata = 8'h00, rdata, d;
	logic [3:0] btn = 4'h0;
	logic [31:0] cnt = 32'h0;
	logic [63:0] val = 64'h0;
	logic [59:0] win;
	step_t step;
	chan_mask_t track_en, wins;
	divider_t div;
	margin_t margin;
	guard_thr_t guard;
	cfg_byte_t exp_q[$];
	int err_count = 0, n_checks = 0;
	integer seed = 32'h9f05ffae;
	cfg_byte_t masks[5] = '{8'h07, 8'hFF, 8'h07, 8'h0F, 8'h07};
	cfg_byte_t rsts[5] = '{8'h03, 8'h00, 8'h03, 8'h08, 8'h00};
	always #2.5 clk = ~clk;
	button_algo_tuning_regs i_button_algo_tuning_regs (
		.CLK(clk), .RST_B(rst_b), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.REG_RD_VALID(rd_valid), .REG_HIT(hit), .BUTTON_A(btn[0]),
		.BUTTON_B(btn[1]), .BUTTON_C(btn[2]), .BUTTON_D(btn[3]),
		.SENSE_CYCLE_COUNT(cnt), .BUTTON_VALUE(val),
		.NORMAL_TRACK_STEP(step), .TRACK_ENABLE(track_en),
		.STRONGEST_WINS(wins), .OSC_DIVIDER(div), .SAMPLE_WINDOW(win),
		.THRESHOLD_MARGIN(margin), .GUARD_THRESHOLD(guard),
		.VALIDATION_VOID(void_all)
	);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
		input string nm);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input cfg_byte_t v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input cfg_byte_t e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask : rd
	// Sampling on the falling edge lets registered outputs settle first.
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wait_n
	task automatic print_verdict();
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			chk(rdata, exp_q.pop_front(), "read data");
		end
	end
	initial begin
		#5000;
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(8'(8'h15 + i), rsts[i]);
		end
		chk(margin, 6'h20, "margin");
		wr(8'h1A, 8'hFF);
		rd(8'h1A, 8'h00);
		rd(8'h14, 8'h00);
		for (int i = 0; i < 5; i++) begin
			d = 8'($random(seed));
			wr(8'(8'h15 + i), d);
			rd(8'(8'h15 + i), d & masks[i]);
		end
		wr(8'h15, 8'hFD);
		wait_n(0);
		chk(step, 3'h5, "step");
		wr(8'h16, 8'hA5);
		btn <= 4'h5;
		wait_n(1);
		chk(track_en, 4'hF, "track enable");
		chk(wins, 4'h5, "group");
		@(posedge clk);
		btn <= 4'hA;
		wait_n(1);
		chk(track_en, 4'h5, "track enable");
		wr(8'h16, 8'h5A);
		btn <= 4'hF;
		wait_n(1);
		chk(track_en, 4'hA, "track enable");
		chk(wins, 4'hA, "group");
		@(posedge clk);
		cnt <= $random(seed);
		wr(8'h17, 8'h02);
		wait_n(1);
		for (int i = 0; i < 4; i++) begin
			chk(win[i*15 +: 15], {cnt[i*8 +: 8], 2'b00}, "window");
		end
		wr(8'h18, 8'h0F);
		wait_n(1);
		chk(margin, 6'h3C, "margin");
		@(posedge clk);
		val <= {32'h0, 16'hFFF4, 16'h0};
		wr(8'h19, 8'hFB);
		wait_n(2);
		chk(guard, 5'h0C, "guard");
		chk(void_all, 1'b0, "void");
		@(posedge clk);
		val <= {32'h0, 16'hFFF3, 16'h0};
		wait_n(1);
		chk(void_all, 1'b1, "void");
		wr(8'h19, 8'h00);
		wait_n(2);
		chk(void_all, 1'b0, "void");
		print_verdict();
	end
endmodule : test_button_algo_tuning_regs
`default_nettype wire

//--- logic/button_algo_tuning_regs.sv
// Overview of operation
// - Three-bit normal-power tracking step in bits 2-0, resets to 3, feeds tracking.
// - Hold bits 7-4 stop a channel's tracking while its button is asserted.
// - With its hold bit clear, a channel tracks whatever its button does.
// - Bits 3-0 place each channel in the strongest-wins group when set.
// - Three-bit divider in bits 2-0 sets sampling window with sense cycle count.
// - Four-bit margin in bits 3-0 gives threshold hysteresis of value times four.
// - Margin register resets to 08h, divider register resets to 03h.
// - Hold and group register resets to 00h: all track, none grouped.
// - Case-deflection guard register sits at 19h and resets to 00h.
// - Nonzero guard voids all buttons when any value is below minus four times it.
`timescale 1ns/100ps
`default_nettype none
`include "button_tuning_params.svh"

module button_algo_tuning_regs #(
	parameter int CW = 8,
	parameter int VW = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Register access port from the host interface
	input wire logic REG_WR_EN,
	input wire logic REG_RD_EN,
	input wire logic [7:0] REG_ADDR,
	input wire button_tuning_pkg::cfg_byte_t REG_WDATA,
	output button_tuning_pkg::cfg_byte_t REG_RDATA,
	output logic REG_RD_VALID,
	output logic REG_HIT,
	// Button output states
	input wire logic BUTTON_A,
	input wire logic BUTTON_B,
	input wire logic BUTTON_C,
	input wire logic BUTTON_D,
	// Channel measurement inputs, channel 0 in the lowest slice
	input wire logic [4*CW-1:0] SENSE_CYCLE_COUNT,
	input wire logic [4*VW-1:0] BUTTON_VALUE,
	// Settings handed to the button algorithm
	output button_tuning_pkg::step_t NORMAL_TRACK_STEP,
	output button_tuning_pkg::chan_mask_t TRACK_ENABLE,
	output button_tuning_pkg::chan_mask_t STRONGEST_WINS,
	output button_tuning_pkg::divider_t OSC_DIVIDER,
	output logic [4*(CW+7)-1:0] SAMPLE_WINDOW,
	output button_tuning_pkg::margin_t THRESHOLD_MARGIN,
	output button_tuning_pkg::guard_thr_t GUARD_THRESHOLD,
	output logic VALIDATION_VOID
);

	import button_tuning_pkg::*;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a >= `OFS_NORMAL_TRACK_STEP) &&
			(a <= `OFS_CASE_DEFLECT_GUARD);
	endfunction : is_mapped

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	// Only implemented fields are stored, so upper bits cannot steer
	// anything and read back as zero without extra masking.
	step_t step_reg, step_next;
	chan_mask_t hold_reg, hold_next;
	chan_mask_t wins_reg, wins_next;
	divider_t div_reg, div_next;
	logic [3:0] margin_reg, margin_next;
	logic [2:0] guard_reg, guard_next;

	always_comb begin
		step_next = step_reg;
		hold_next = hold_reg;
		wins_next = wins_reg;
		div_next = div_reg;
		margin_next = margin_reg;
		guard_next = guard_reg;
		if (REG_WR_EN) begin
			case (REG_ADDR)
				`OFS_NORMAL_TRACK_STEP: begin
					step_next = REG_WDATA[`STEP_MSB:`STEP_LSB];
				end
				`OFS_TRACK_HOLD_GROUP: begin
					hold_next = REG_WDATA[`HOLD_MSB:`HOLD_LSB];
					wins_next = REG_WDATA[`WINS_MSB:`WINS_LSB];
				end
				`OFS_OSC_DIVIDER: begin
					div_next = REG_WDATA[`DIV_MSB:`DIV_LSB];
				end
				`OFS_THRESHOLD_MARGIN: begin
					margin_next = REG_WDATA[`MARGIN_MSB:`MARGIN_LSB];
				end
				`OFS_CASE_DEFLECT_GUARD: begin
					guard_next = REG_WDATA[`GUARD_MSB:`GUARD_LSB];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			step_reg <= 3'(`RST_NORMAL_TRACK_STEP);
			hold_reg <= 4'(`RST_TRACK_HOLD_GROUP >>
				`HOLD_LSB);
			wins_reg <= 4'(`RST_TRACK_HOLD_GROUP);
			div_reg <= 3'(`RST_OSC_DIVIDER);
			margin_reg <= 4'(`RST_THRESHOLD_MARGIN);
			guard_reg <= 3'(`RST_CASE_DEFLECT_GUARD);
		end else begin
			step_reg <= step_next;
			hold_reg <= hold_next;
			wins_reg <= wins_next;
			div_reg <= div_next;
			margin_reg <= margin_next;
			guard_reg <= guard_next;
		end
	end

	// ------------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------------
	cfg_byte_t rdata_reg, rdata_next;
	logic rd_valid_reg, rd_valid_next;
	logic hit_reg, hit_next;

	always_comb begin
		rdata_next = rdata_reg;
		rd_valid_next = REG_RD_EN;
		hit_next = (REG_RD_EN || REG_WR_EN) && is_mapped(REG_ADDR);
		if (REG_RD_EN) begin
			case (REG_ADDR)
				`OFS_NORMAL_TRACK_STEP: rdata_next = {5'h00, step_reg};
				`OFS_TRACK_HOLD_GROUP: rdata_next = {hold_reg, wins_reg};
				`OFS_OSC_DIVIDER: rdata_next = {5'h00, div_reg};
				`OFS_THRESHOLD_MARGIN: rdata_next = {4'h0, margin_reg};
				`OFS_CASE_DEFLECT_GUARD: rdata_next = {5'h00, guard_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			hit_reg <= hit_next;
		end
	end

	// ------------------------------------------------------------------
	// Algorithm settings
	// ------------------------------------------------------------------
	// The window is a shift of the cycle count, which keeps the path to a
	// mux rather than a multiplier at 200 MHz.
	logic [3:0] btn_now;
	chan_mask_t track_next, track_reg;
	logic [4*(CW+7)-1:0] window_next, window_reg;
	margin_t margin_out_reg, margin_out_next;
	guard_thr_t guard_thr_reg, guard_thr_next;
	logic void_comb, void_reg, void_next;

	assign btn_now = {BUTTON_D, BUTTON_C, BUTTON_B, BUTTON_A};

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			assign track_next[i] = !(hold_reg[i] && btn_now[i]);
			assign window_next[i*(CW+7) +: (CW+7)] =
				{7'h00, SENSE_CYCLE_COUNT[i*CW +: CW]} << div_reg;
		end
	endgenerate

	always_comb begin
		margin_out_next = {margin_reg, 2'b00};
		guard_thr_next = {guard_reg, 2'b00};
		void_next = void_comb;
	end

	case_deflect_check #(
		.VW(VW)
	) u_guard (
		.threshold(guard_thr_reg),
		.values(BUTTON_VALUE),
		.void_all(void_comb)
	);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			track_reg <= 4'hF;
			window_reg <= '0;
			margin_out_reg <= 6'h20;
			guard_thr_reg <= 5'h00;
			void_reg <= 1'b0;
		end else begin
			track_reg <= track_next;
			window_reg <= window_next;
			margin_out_reg <= margin_out_next;
			guard_thr_reg <= guard_thr_next;
			void_reg <= void_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign REG_RDATA = rdata_reg;
	assign REG_RD_VALID = rd_valid_reg;
	assign REG_HIT = hit_reg;
	assign NORMAL_TRACK_STEP = step_reg;
	assign TRACK_ENABLE = track_reg;
	assign STRONGEST_WINS = wins_reg;
	assign OSC_DIVIDER = div_reg;
	assign SAMPLE_WINDOW = window_reg;
	assign THRESHOLD_MARGIN = margin_out_reg;
	assign GUARD_THRESHOLD = guard_thr_reg;
	assign VALIDATION_VOID = void_reg;

endmodule : button_algo_tuning_regs

`default_nettype wire

//--- logic/button_tuning_params.svh
`ifndef BUTTON_TUNING_PARAMS_SVH
`define BUTTON_TUNING_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_NORMAL_TRACK_STEP 8'h15
`define OFS_TRACK_HOLD_GROUP 8'h16
`define OFS_OSC_DIVIDER 8'h17
`define OFS_THRESHOLD_MARGIN 8'h18
`define OFS_CASE_DEFLECT_GUARD 8'h19

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_NORMAL_TRACK_STEP 8'h03
`define RST_TRACK_HOLD_GROUP 8'h00
`define RST_OSC_DIVIDER 8'h03
`define RST_THRESHOLD_MARGIN 8'h08
`define RST_CASE_DEFLECT_GUARD 8'h00

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define STEP_MSB 2
`define STEP_LSB 0
`define HOLD_MSB 7
`define HOLD_LSB 4
`define WINS_MSB 3
`define WINS_LSB 0
`define DIV_MSB 2
`define DIV_LSB 0
`define MARGIN_MSB 3
`define MARGIN_LSB 0
`define GUARD_MSB 2
`define GUARD_LSB 0

// ----------------------------------------------------------------------
// Scale factors
// ----------------------------------------------------------------------
`define MARGIN_SCALE_SHIFT 2
`define GUARD_SCALE_SHIFT 2

`endif

//--- logic/button_tuning_pkg.sv
`default_nettype none
package button_tuning_pkg;

	typedef logic [7:0] cfg_byte_t;
	typedef logic [3:0] chan_mask_t;
	typedef logic [2:0] step_t;
	typedef logic [2:0] divider_t;
	typedef logic [5:0] margin_t;
	typedef logic [4:0] guard_thr_t;

endpackage : button_tuning_pkg
`default_nettype wire

//--- logic/case_deflect_check.sv
`timescale 1ns/100ps
`default_nettype none

module case_deflect_check #(
	parameter int VW = 16
) (
	// Guard threshold, zero disables.
	input wire logic [4:0] threshold,
	// Signed button values of the four channels, channel 0 lowest.
	input wire logic [4*VW-1:0] values,
	// High when the presses of all buttons must be voided.
	output logic void_all
);

	logic [3:0] below;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			assign below[i] = $signed(values[i*VW +: VW]) <
				-$signed({{(VW-5){1'b0}}, threshold});
		end
	endgenerate

	assign void_all = (threshold != 5'h00) && (|below);

endmodule : case_deflect_check

`default_nettype wire
